/* trwa_cfg.svh */
`ifndef TRWA_CFG_SVH
`define TRWA_CFG_SVH

// timing
`define TRWA_CLK_PERIOD_NS  50
`define TRWA_PULSE_GAP_NS   1000
`define TRWA_PULSE_GAP_CYC  (`TRWA_PULSE_GAP_NS / `TRWA_CLK_PERIOD_NS)

// data widths and buffering
`define TRWA_GROUP_W        6
`define TRWA_HALF_W         18
`define TRWA_FIFO_DEPTH     16
`define TRWA_GROUPS_PER_HALF 2'h3

// register offsets (byte addresses)
`define TRWA_ADDR_W         8
`define TRWA_OFS_CTRL       8'h00
`define TRWA_OFS_STATUS     8'h04
`define TRWA_OFS_BUF_HIGH   8'h08
`define TRWA_OFS_BUF_LOW    8'h0C
`define TRWA_OFS_SHIFT      8'h10

// control register fields
`define TRWA_CTRL_READ_BIT  0
`define TRWA_CTRL_FWD_BIT   1
`define TRWA_CTRL_REV_BIT   2
`define TRWA_CTRL_WPREP_BIT 3
`define TRWA_CTRL_RESET     4'h0

// status register fields
`define TRWA_STAT_CT_BIT    0
`define TRWA_STAT_SWAP_BIT  1
`define TRWA_STAT_REQ_BIT   2
`define TRWA_STAT_BUSY_BIT  3
`define TRWA_STAT_FULL_BIT  4

`endif

/* trwa_pkg.sv */
package trwa_pkg;

  typedef enum logic [1:0] {
    TRWA_S_IDLE  = 2'b00,
    TRWA_S_PULSE = 2'b01,
    TRWA_S_WAIT  = 2'b10
  } trwa_seq_t;

  typedef enum logic [2:0] {
    TRWA_P1 = 3'b001,
    TRWA_P2 = 3'b010,
    TRWA_P3 = 3'b011,
    TRWA_P4 = 3'b100,
    TRWA_P5 = 3'b101,
    TRWA_P6 = 3'b110
  } trwa_pulse_t;

  typedef logic [17:0] trwa_half_t;

endpackage

/* trwa_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module trwa_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready,
  // status
  output logic                  full
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign full      = (count_ff == (AW+1)'(DEPTH));
  assign in_ready  = !full;
  assign out_valid = (count_ff != '0);
  assign out_data  = mem[rd_ptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // a group offered while full must leave the store and the count alone
  AST_FIFO_NO_OVERFLOW: assert property (
    @(posedge clk) disable iff (reset)
    full && !out_ready |=> full && $stable(wr_ptr_ff))
    else $error("fifo took a group while full");

endmodule

`default_nettype wire

/* trwa_delay.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trwa_cfg.svh"

module trwa_delay (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // control
  input  wire logic start,
  output logic      done
);

  localparam int DLY = `TRWA_PULSE_GAP_CYC;

  logic [7:0] cnt_ff;

  // done comes DLY cycles after start
  assign done = (cnt_ff == 8'h01);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= 8'h00;
    end else if (start) begin
      cnt_ff <= 8'(DLY);
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end

  AST_GAP_LENGTH: assert property (
    @(posedge clk) disable iff (reset) start |-> ##DLY done)
    else $error("pulse gap is not one microsecond");

endmodule

`default_nettype wire

/* trwa_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trwa_cfg.svh"

// Overview of operation
// - fifth pulse: high half down, shift up
// - fifth pulse, no swap: sixth, toggle counter
// - word input clears request, drives buffer
// - keep assembling words without new command
// - reverse first pulse shifts one group left
// - reverse load exchanges the two mixer bytes
// - second pulse not forward: rotate end-around
// - third strobe reverse: extra rotate third pulse
// - reverse counter set: swap, reload low half
// - hold finished word until word input
module trwa_top (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset,
  // register port
  input  wire logic [`TRWA_ADDR_W-1:0]      reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_write,
  input  wire logic                         reg_read,
  output logic      [31:0]                  reg_rdata,
  // tape data mixer
  input  wire logic                         tape_data_strobe,
  input  wire logic [`TRWA_GROUP_W-1:0]     mixer_data,
  output logic                              strobe_ready,
  // processor word transfer
  input  wire logic                         word_input_instruction,
  output logic                              word_transfer_request,
  output logic      [35:0]                  word_bus,
  output logic                              word_bus_valid
);
  import trwa_pkg::*;

  // bit 00 of the documented numbering is the msb here
  function automatic trwa_pkg::trwa_half_t rotate_end_around(
    input trwa_pkg::trwa_half_t v);
    return {v[11:0], v[17:12]};
  endfunction

  function automatic logic addr_hit(input logic [`TRWA_ADDR_W-1:0] a,
                                    input logic [`TRWA_ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  trwa_seq_t                 state_ff;
  trwa_pulse_t               pulse_ff;
  trwa_pulse_t               after_gap_ff;
  trwa_half_t                assembly_shift_reg_ff;
  trwa_half_t                buffer_high_half_ff;
  trwa_half_t                buffer_low_half_ff;
  logic [`TRWA_GROUP_W-1:0]  group_ff;
  logic [1:0]                group_cnt_ff;
  logic                      half_word_counter_ff;
  logic                      half_swap_flag_ff;
  logic                      word_transfer_request_ff;
  logic [35:0]               word_bus_ff;
  logic                      word_bus_valid_ff;
  logic [31:0]               reg_rdata_ff;
  logic                      read_function_cmd_ff;
  logic                      dir_forward_cmd_ff;
  logic                      dir_reverse_cmd_ff;
  logic                      write_prep_flag_ff;

  logic                      fifo_valid;
  logic [`TRWA_GROUP_W-1:0]  fifo_data;
  logic                      fifo_pop;
  logic                      fifo_full;
  logic                      gap_start;
  logic                      gap_done;
  logic                      seq_pulse_first;
  logic                      seq_pulse_second;
  logic                      seq_pulse_third;
  logic                      seq_pulse_fourth;
  logic                      seq_pulse_fifth;
  logic                      seq_pulse_sixth;
  logic                      last_group;
  logic                      rev_read;
  logic                      request_set;
  logic                      word_taken;
  logic [31:0]               nxt_rdata;

  assign seq_pulse_first  = (state_ff == TRWA_S_PULSE) && (pulse_ff == TRWA_P1);
  assign seq_pulse_second = (state_ff == TRWA_S_PULSE) && (pulse_ff == TRWA_P2);
  assign seq_pulse_third  = (state_ff == TRWA_S_PULSE) && (pulse_ff == TRWA_P3);
  assign seq_pulse_fourth = (state_ff == TRWA_S_PULSE) && (pulse_ff == TRWA_P4);
  assign seq_pulse_fifth  = (state_ff == TRWA_S_PULSE) && (pulse_ff == TRWA_P5);
  assign seq_pulse_sixth  = (state_ff == TRWA_S_PULSE) && (pulse_ff == TRWA_P6);

  assign last_group = (group_cnt_ff == `TRWA_GROUPS_PER_HALF);
  assign rev_read   = dir_reverse_cmd_ff && read_function_cmd_ff;

  // a finished word blocks the next group so the buffer cannot be overrun
  assign fifo_pop = (state_ff == TRWA_S_IDLE) && fifo_valid
                    && read_function_cmd_ff
                    && !word_transfer_request_ff;
  assign request_set = seq_pulse_sixth && half_word_counter_ff;
  assign word_taken  = word_input_instruction && word_transfer_request_ff;

  trwa_fifo #(
    .WIDTH (`TRWA_GROUP_W),
    .DEPTH (`TRWA_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (tape_data_strobe),
    .in_data   (mixer_data),
    .in_ready  (strobe_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop),
    .full      (fifo_full)
  );

  trwa_delay u_gap (
    .clk   (clk),
    .reset (reset),
    .start (gap_start),
    .done  (gap_done)
  );

  // every pulse waits one gap except the sixth, the fifth-to-sixth step and a second pulse not followed by a third
  assign gap_start = (state_ff == TRWA_S_PULSE) && (pulse_ff != TRWA_P6)
                     && !(seq_pulse_fifth && !half_swap_flag_ff)
                     && !(seq_pulse_second
                          && !(last_group && read_function_cmd_ff));

  // pulse sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff     <= TRWA_S_IDLE;
      pulse_ff     <= TRWA_P1;
      after_gap_ff <= TRWA_P2;
    end else begin
      case (state_ff)
        TRWA_S_IDLE: begin
          if (fifo_pop) begin
            state_ff <= TRWA_S_PULSE;
            pulse_ff <= TRWA_P1;
          end
        end
        TRWA_S_PULSE: begin
          case (pulse_ff)
            TRWA_P1: begin
              state_ff     <= TRWA_S_WAIT;
              after_gap_ff <= TRWA_P2;
            end
            TRWA_P2: begin
              if (last_group && read_function_cmd_ff) begin
                state_ff     <= TRWA_S_WAIT;
                after_gap_ff <= TRWA_P3;
              end else begin
                state_ff <= TRWA_S_IDLE;
              end
            end
            TRWA_P3: begin
              state_ff     <= TRWA_S_WAIT;
              after_gap_ff <= TRWA_P4;
            end
            TRWA_P4: begin
              state_ff     <= TRWA_S_WAIT;
              after_gap_ff <= TRWA_P5;
            end
            TRWA_P5: begin
              if (half_swap_flag_ff) begin
                state_ff     <= TRWA_S_WAIT;
                after_gap_ff <= TRWA_P4;
              end else begin
                pulse_ff <= TRWA_P6;
              end
            end
            TRWA_P6: begin
              state_ff <= TRWA_S_IDLE;
            end
            default: begin
              state_ff <= TRWA_S_IDLE;
            end
          endcase
        end
        TRWA_S_WAIT: begin
          if (gap_done) begin
            state_ff <= TRWA_S_PULSE;
            pulse_ff <= after_gap_ff;
          end
        end
        default: begin
          state_ff <= TRWA_S_IDLE;
        end
      endcase
    end
  end

  // group capture and count within a half word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      group_ff     <= '0;
      group_cnt_ff <= 2'h0;
    end else begin
      if (fifo_pop) begin
        group_ff <= fifo_data;
      end
      if (seq_pulse_first) begin
        group_cnt_ff <= group_cnt_ff + 2'h1;
      end else if (seq_pulse_second && last_group) begin
        group_cnt_ff <= 2'h0;
      end
    end
  end

  // assembly shift register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      assembly_shift_reg_ff <= '0;
    end else if (seq_pulse_first) begin
      if (write_prep_flag_ff) begin
        assembly_shift_reg_ff <= {assembly_shift_reg_ff[11:0], 6'h00};
      end else if (dir_forward_cmd_ff) begin
        assembly_shift_reg_ff <= {assembly_shift_reg_ff[11:0], group_ff};
      end else begin
        // reverse tape presents the two 3-bit bytes in swapped order
        assembly_shift_reg_ff <= {assembly_shift_reg_ff[11:0],
                                  group_ff[2:0], group_ff[5:3]};
      end
    end else if (seq_pulse_second && !dir_forward_cmd_ff) begin
      assembly_shift_reg_ff <= rotate_end_around(assembly_shift_reg_ff);
    end else if (seq_pulse_third && dir_reverse_cmd_ff) begin
      assembly_shift_reg_ff <= rotate_end_around(assembly_shift_reg_ff);
    end else if (seq_pulse_fourth && half_swap_flag_ff) begin
      assembly_shift_reg_ff <= buffer_low_half_ff;
    end else if (seq_pulse_fifth && half_swap_flag_ff) begin
      assembly_shift_reg_ff <= '0;
    end
  end

  // buffer halves
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      buffer_high_half_ff <= '0;
      buffer_low_half_ff  <= '0;
    end else if (seq_pulse_fifth) begin
      buffer_low_half_ff  <= buffer_high_half_ff;
      buffer_high_half_ff <= assembly_shift_reg_ff;
    end
  end

  // half-word counter and swap flag
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      half_word_counter_ff <= 1'b0;
      half_swap_flag_ff    <= 1'b0;
    end else begin
      if (seq_pulse_sixth) begin
        half_word_counter_ff <= !half_word_counter_ff;
      end
      if (seq_pulse_fourth && rev_read && half_word_counter_ff) begin
        half_swap_flag_ff <= !half_swap_flag_ff;
      end
    end
  end

  // transfer request; a new request wins over a same-cycle answer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      word_transfer_request_ff <= 1'b0;
    end else if (request_set) begin
      word_transfer_request_ff <= 1'b1;
    end else if (word_taken) begin
      word_transfer_request_ff <= 1'b0;
    end
  end

  // word onto the processor bus
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      word_bus_ff       <= '0;
      word_bus_valid_ff <= 1'b0;
    end else begin
      word_bus_valid_ff <= word_taken;
      if (word_taken) begin
        word_bus_ff <= {buffer_low_half_ff, buffer_high_half_ff};
      end
    end
  end

  // control register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {write_prep_flag_ff, dir_reverse_cmd_ff,
       dir_forward_cmd_ff, read_function_cmd_ff} <= `TRWA_CTRL_RESET;
    end else if (reg_write && addr_hit(reg_addr, `TRWA_OFS_CTRL)) begin
      read_function_cmd_ff <= reg_wdata[`TRWA_CTRL_READ_BIT];
      dir_forward_cmd_ff   <= reg_wdata[`TRWA_CTRL_FWD_BIT];
      dir_reverse_cmd_ff   <= reg_wdata[`TRWA_CTRL_REV_BIT];
      write_prep_flag_ff   <= reg_wdata[`TRWA_CTRL_WPREP_BIT];
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (addr_hit(reg_addr, `TRWA_OFS_CTRL)) begin
      nxt_rdata[`TRWA_CTRL_READ_BIT]  = read_function_cmd_ff;
      nxt_rdata[`TRWA_CTRL_FWD_BIT]   = dir_forward_cmd_ff;
      nxt_rdata[`TRWA_CTRL_REV_BIT]   = dir_reverse_cmd_ff;
      nxt_rdata[`TRWA_CTRL_WPREP_BIT] = write_prep_flag_ff;
    end else if (addr_hit(reg_addr, `TRWA_OFS_STATUS)) begin
      nxt_rdata[`TRWA_STAT_CT_BIT]   = half_word_counter_ff;
      nxt_rdata[`TRWA_STAT_SWAP_BIT] = half_swap_flag_ff;
      nxt_rdata[`TRWA_STAT_REQ_BIT]  = word_transfer_request_ff;
      nxt_rdata[`TRWA_STAT_BUSY_BIT] = (state_ff != TRWA_S_IDLE);
      nxt_rdata[`TRWA_STAT_FULL_BIT] = fifo_full;
    end else if (addr_hit(reg_addr, `TRWA_OFS_BUF_HIGH)) begin
      nxt_rdata[17:0] = buffer_high_half_ff;
    end else if (addr_hit(reg_addr, `TRWA_OFS_BUF_LOW)) begin
      nxt_rdata[17:0] = buffer_low_half_ff;
    end else if (addr_hit(reg_addr, `TRWA_OFS_SHIFT)) begin
      nxt_rdata[17:0] = assembly_shift_reg_ff;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else if (reg_read) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= 32'h0000_0000;
    end
  end

  assign reg_rdata             = reg_rdata_ff;
  assign word_transfer_request = word_transfer_request_ff;
  assign word_bus              = word_bus_ff;
  assign word_bus_valid        = word_bus_valid_ff;

  AST_FIFTH_MOVES_HALVES: assert property (
    @(posedge clk) disable iff (reset)
    seq_pulse_fifth |=> buffer_low_half_ff == $past(buffer_high_half_ff)
                        && buffer_high_half_ff == $past(assembly_shift_reg_ff))
    else $error("fifth pulse did not move buffer halves");

  AST_SIXTH_TOGGLES: assert property (
    @(posedge clk) disable iff (reset)
    seq_pulse_fifth && !half_swap_flag_ff
    |=> seq_pulse_sixth ##1 half_word_counter_ff != $past(half_word_counter_ff))
    else $error("sixth pulse or counter toggle missing");

  AST_REQUEST_AT_ZERO: assert property (
    @(posedge clk) disable iff (reset)
    seq_pulse_sixth && half_word_counter_ff |=> word_transfer_request_ff)
    else $error("request not raised when counter returned to zero");

  AST_WORD_INPUT: assert property (
    @(posedge clk) disable iff (reset)
    word_taken && !request_set
    |=> !word_transfer_request_ff && word_bus_valid_ff
        && word_bus_ff == {$past(buffer_low_half_ff),
                           $past(buffer_high_half_ff)})
    else $error("word input did not deliver buffer and clear request");

  AST_REVERSE_LOAD: assert property (
    @(posedge clk) disable iff (reset)
    seq_pulse_first && !dir_forward_cmd_ff && !write_prep_flag_ff
    |=> assembly_shift_reg_ff == {$past(assembly_shift_reg_ff[11:0]),
                                  $past(group_ff[2:0]), $past(group_ff[5:3])})
    else $error("reverse group load wrong");

  AST_SECOND_ROTATE: assert property (
    @(posedge clk) disable iff (reset)
    seq_pulse_second && !dir_forward_cmd_ff
    |=> assembly_shift_reg_ff
        == rotate_end_around($past(assembly_shift_reg_ff)))
    else $error("end-around rotation missing on second pulse");

  AST_THIRD_ROTATE: assert property (
    @(posedge clk) disable iff (reset)
    seq_pulse_third && dir_reverse_cmd_ff
    |=> assembly_shift_reg_ff
        == rotate_end_around($past(assembly_shift_reg_ff)))
    else $error("extra rotation missing on third pulse");

  AST_SWAP_SET: assert property (
    @(posedge clk) disable iff (reset)
    seq_pulse_fourth && rev_read && half_word_counter_ff && !half_swap_flag_ff
    |=> half_swap_flag_ff)
    else $error("swap flag not set on reverse fourth pulse");

  AST_HOLD_WORD: assert property (
    @(posedge clk) disable iff (reset)
    word_transfer_request_ff && !word_input_instruction
    |=> $stable(buffer_high_half_ff) && $stable(buffer_low_half_ff))
    else $error("buffer changed while word awaits transfer");

  COV_FORWARD_WORD: cover property (
    @(posedge clk) disable iff (reset)
    dir_forward_cmd_ff && request_set);

  COV_REVERSE_SWAP: cover property (
    @(posedge clk) disable iff (reset)
    seq_pulse_fourth && half_swap_flag_ff);

  COV_WORD_TAKEN: cover property (
    @(posedge clk) disable iff (reset) word_taken);

  COV_FIFO_FULL: cover property (
    @(posedge clk) disable iff (reset) fifo_full && tape_data_strobe);

endmodule

`default_nettype wire

/* trwa_far_end.sv */
`timescale 1ns/1ps
`default_nettype none

module trwa_far_end (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // mixer side
  input  wire logic        strobe_ready,
  output logic             tape_data_strobe,
  output logic [5:0]       mixer_data,
  // processor side
  input  wire logic        word_transfer_request,
  input  wire logic [35:0] word_bus,
  input  wire logic        word_bus_valid,
  output logic             word_input_instruction
);
  logic [5:0]  tx_q[$];
  logic [35:0] rx_q[$];
  int          tx_n = 0;
  int          wcnt = 0;
  int          ans_delay = 3;
  bit          hold = 0;
  bit          stray = 0;

  initial begin
    tape_data_strobe = 1'b0;
    mixer_data = 6'h00;
    word_input_instruction = 1'b0;
  end

  // idle data toggles so a stale group never looks valid
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tape_data_strobe <= 1'b0;
    end else begin
      if (tape_data_strobe && strobe_ready) tx_n++;
      if (tx_n < tx_q.size()) begin
        tape_data_strobe <= 1'b1;
        mixer_data <= tx_q[tx_n];
      end else begin
        tape_data_strobe <= 1'b0;
        mixer_data <= ~mixer_data;
      end
    end
  end

  // hold lets the bench keep a finished word waiting
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      word_input_instruction <= 1'b0;
      wcnt = 0;
    end else begin
      if (word_bus_valid) rx_q.push_back(word_bus);
      if (word_input_instruction) begin
        word_input_instruction <= 1'b0;
      end else if (stray) begin
        word_input_instruction <= 1'b1;
        stray = 0;
      end else if (word_transfer_request && !hold) begin
        wcnt++;
        if (wcnt > ans_delay) begin
          word_input_instruction <= 1'b1;
          wcnt = 0;
        end
      end
    end
  end
endmodule

`default_nettype wire

/* trwa_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module trwa_top_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic        strobe;
  logic        ready;
  logic        instr;
  logic        req;
  logic        bus_valid;
  logic [5:0]  mdata;
  logic [35:0] bus;
  logic [31:0] rv;
  logic [35:0] exp_w[$];
  int          errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          t0;

  always #25 clk = ~clk;
  always @(posedge clk) cyc++;

  trwa_top u_dut (
    .clk                   (clk),
    .reset                 (reset),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_write             (reg_write),
    .reg_read              (reg_read),
    .reg_rdata             (reg_rdata),
    .tape_data_strobe      (strobe),
    .mixer_data            (mdata),
    .strobe_ready          (ready),
    .word_input_instruction(instr),
    .word_transfer_request (req),
    .word_bus              (bus),
    .word_bus_valid        (bus_valid)
  );

  trwa_far_end u_far (
    .clk                   (clk),
    .reset                 (reset),
    .strobe_ready          (ready),
    .tape_data_strobe      (strobe),
    .mixer_data            (mdata),
    .word_transfer_request (req),
    .word_bus              (bus),
    .word_bus_valid        (bus_valid),
    .word_input_instruction(instr)
  );

  task automatic conclude;
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [35:0] e,
                     input logic [35:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    // read data stand for this one cycle only; take them mid-cycle
    @(negedge clk);
    d = reg_rdata;
  endtask

  // reverse words come out group-reversed with the two bytes exchanged
  task automatic send(input int base, input bit rev, input bit zero);
    logic [5:0]  g;
    logic [35:0] w;
    w = 36'h0;
    @(negedge clk);
    for (int i = 0; i < 6; i++) begin
      g = 6'((base * 6 + i) * 7 + 3);
      u_far.tx_q.push_back(g);
      if (rev) w[6*i +: 6] = {g[2:0], g[5:3]};
      else w[35-6*i -: 6] = g;
    end
    exp_w.push_back(zero ? 36'h0 : w);
  endtask

  task automatic wait_words(input int n);
    for (int k = 0; k < 3000 && u_far.rx_q.size() < n; k++)
      @(posedge clk);
    chk("word count", 36'(n), 36'(u_far.rx_q.size()));
  endtask

  task automatic check_words;
    while (exp_w.size() > 0 && u_far.rx_q.size() > 0)
      chk("word", exp_w.pop_front(), u_far.rx_q.pop_front());
  endtask

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(8'h00, rv);
    chk("ctrl", 36'h0, 36'(rv));
    rd(8'h04, rv);
    chk("status", 36'h0, 36'(rv));
    wr(8'h00, 32'h3);
    u_far.hold = 1;
    t0 = cyc;
    send(0, 0, 0);
    for (int k = 0; k < 1000 && req !== 1'b1; k++) @(posedge clk);
    chk("word time", 36'h1, 36'(cyc - t0 >= 240 && cyc - t0 <= 320));
    rd(8'h0C, rv);
    chk("low half", 36'(exp_w[0][35:18]), 36'(rv));
    rd(8'h08, rv);
    chk("high half", 36'(exp_w[0][17:0]), 36'(rv));
    rd(8'h04, rv);
    chk("status", 36'h4, 36'(rv[2:0]));
    send(1, 0, 0);
    send(2, 0, 0);
    send(3, 0, 0);
    repeat (40) @(posedge clk);
    chk("ready", 36'h0, 36'(ready));
    rd(8'h04, rv);
    chk("full", 36'h1, 36'(rv[4]));
    chk("held", 36'h1, 36'(req));
    u_far.hold = 0;
    wait_words(4);
    check_words();
    chk("ready", 36'h1, 36'(ready));
    @(negedge clk) u_far.stray = 1;
    repeat (5) @(posedge clk);
    chk("stray", 36'h0, 36'(u_far.rx_q.size()));
    rd(8'h14, rv);
    chk("unmapped", 36'h0, 36'(rv));
    wr(8'h20, 32'hF);
    rd(8'h00, rv);
    chk("ctrl", 36'h3, 36'(rv));
    wr(8'h00, 32'h5);
    u_far.ans_delay = 40;
    send(4, 1, 0);
    send(5, 1, 0);
    wait_words(2);
    check_words();
    wr(8'h00, 32'hB);
    u_far.ans_delay = 0;
    send(6, 0, 1);
    wait_words(1);
    check_words();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule

`default_nettype wire
